// file: design/lco_pkg.sv
// Contract
// - Init reads 48-byte constants area, latches all
// - Echo bit routes line rx to tx
// - Sticky request-to-send held from first request
// - Otherwise request-to-send only while frames pending
// - Destuff bypass; clear-to-send becomes rx strobe
// - Loopback ties tx to rx, no RTS
// - Burst limit caps DMA at eight cycles
// - Stuff bypass; request-to-send becomes tx strobe
// - Memory-to-memory mode runs procedures in memory
// - Promiscuous accepts all frames into pool zero
// - Filter active only with promiscuous receive
// - Polling suppresses interrupt except bus errors
// - Non-polling posts event and asserts interrupt
// - Frame-reject bit gates reject frame transmission
// - System mode picks on-chip or expanded matching
// - Variant bit selects Q.920/Q.921 or alternative
// - Flip bit inverts received address low bit
package lco_pkg;
  localparam int          CONST_BYTES   = 48;
  localparam int          CONST_WORDS   = CONST_BYTES / 2;
  localparam logic [4:0]  LAST_WORD     = 5'h17;
  localparam logic [4:0]  OPT1_WORD     = 5'h00;
  localparam logic [4:0]  OPT2_WORD     = 5'h01;
  localparam logic [23:0] CONST_BASE    = 24'h000000;
  localparam int          ECHO_BIT      = 13;
  localparam int          STICKY_BIT    = 12;
  localparam int          RXBYP_BIT     = 11;
  localparam int          LOOP_BIT      = 10;
  localparam int          BURST_BIT     = 9;
  localparam int          TXBYP_BIT     = 8;
  localparam int          M2M_BIT       = 5;
  localparam int          PROMISC_BIT   = 4;
  localparam int          FILTER_BIT    = 3;
  localparam int          POLL_BIT      = 2;
  localparam int          FRMR_BIT      = 1;
  localparam int          SYSMODE_BIT   = 0;
  localparam int          VARIANT_BIT   = 4;
  localparam int          FLIP_BIT      = 3;
  localparam logic [3:0]  BURST_LIMIT   = 4'h8;
  localparam logic [15:0] OPT_RESET     = 16'h0000;

  typedef struct packed {
    logic echo;
    logic sticky_rts;
    logic rx_bypass;
    logic loopback;
    logic burst_limit;
    logic tx_bypass;
    logic mem_to_mem_enable;
    logic promiscuous;
    logic filter;
    logic polling;
    logic reject_frame_tx_enable;
    logic onchip_match;
    logic protocol_variant_select;
    logic flip;
  } lco_opts_t;
endpackage

// file: design/lco_top.sv
`timescale 1ns/1ps
module lco_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        init_cmd,
  input  wire logic        tx_req_cmd,
  input  wire logic        tx_pending,
  output logic [23:0]      mem_addr,
  output logic             mem_rd,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  output logic             init_busy,
  output logic [15:0]      global_options_primary,
  output logic [15:0]      global_options_secondary,
  output logic             serial_tx_data,
  input  wire logic        serial_rx_data,
  input  wire logic        serial_tx_clock,
  input  wire logic        cts_pin,
  output logic             rts_pin,
  input  wire logic        core_tx_data,
  input  wire logic        core_tx_rts,
  output logic             core_rx_data,
  output logic             core_rx_sample,
  output logic             rx_start_strobe,
  input  wire logic        dma_cycle,
  output logic             dma_burst_end,
  input  wire logic        event_post,
  input  wire logic        bus_error,
  output logic             irq,
  input  wire logic        frmr_detect,
  output logic             frmr_tx,
  input  wire logic [12:0] rx_dlci,
  output logic [12:0]      rx_dlci_eff,
  output logic             match_bypass,
  output logic             filter_enable,
  output logic             expanded_mode,
  output logic             mem_to_mem_enable,
  output logic             protocol_variant_select,
  output logic             rx_destuff_enable,
  output logic             tx_stuff_enable
);
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} lco_state_t;

  lco_state_t       state_reg, state_next;
  logic [4:0]       idx_reg, idx_next;
  logic [15:0]      opt1_reg, opt1_next;
  logic [15:0]      opt2_reg, opt2_next;
  logic [15:0]      word_reg [0:lco_pkg::CONST_WORDS-1];
  logic             sticky_on_reg, sticky_on_next;
  logic [3:0]       burst_reg, burst_next;
  logic [2:0]       rxd_sync_reg, cts_sync_reg, tclk_sync_reg;
  logic             out_tx_reg, rts_reg, rxd_o_reg, rxs_reg, rx_start_strobe_reg;
  logic             bend_reg, irq_reg, frmr_reg;
  logic [12:0]      dlci_reg;
  lco_pkg::lco_opts_t opts;

  localparam int CONST_WORDS = lco_pkg::CONST_WORDS;

  function automatic logic [23:0] word_addr(input logic [4:0] i);
    word_addr = lco_pkg::CONST_BASE + {18'h00000, i, 1'b0};
  endfunction

  // Option word decode, shared by latched and next views
  function automatic lco_pkg::lco_opts_t decode_opts(input logic [15:0] w1,
                                                      input logic [15:0] w2);
    lco_pkg::lco_opts_t o;
    o.echo                    = w1[lco_pkg::ECHO_BIT];
    o.sticky_rts              = w1[lco_pkg::STICKY_BIT];
    o.rx_bypass               = w1[lco_pkg::RXBYP_BIT];
    o.loopback                = w1[lco_pkg::LOOP_BIT];
    o.burst_limit             = w1[lco_pkg::BURST_BIT];
    o.tx_bypass               = w1[lco_pkg::TXBYP_BIT];
    o.mem_to_mem_enable       = w1[lco_pkg::M2M_BIT];
    o.promiscuous             = w1[lco_pkg::PROMISC_BIT];
    o.filter                  = w1[lco_pkg::FILTER_BIT];
    o.polling                 = w1[lco_pkg::POLL_BIT];
    o.reject_frame_tx_enable  = w1[lco_pkg::FRMR_BIT];
    o.onchip_match            = w1[lco_pkg::SYSMODE_BIT];
    o.protocol_variant_select = w2[lco_pkg::VARIANT_BIT];
    o.flip                    = w2[lco_pkg::FLIP_BIT];
    decode_opts = o;
  endfunction

  // Decoded view of latched words
  always_comb begin
    opts = decode_opts(opt1_reg, opt2_reg);
  end

  // Loader: word by word read of the constants area
  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    opt1_next  = opt1_reg;
    opt2_next  = opt2_reg;
    case (state_reg)
      ST_IDLE: begin
        if (init_cmd) begin
          state_next = ST_REQ;
          idx_next   = 5'h00;
        end
      end
      ST_REQ: state_next = ST_WAIT;
      ST_WAIT: begin
        if (mem_ack) begin
          if (idx_reg == lco_pkg::OPT1_WORD) opt1_next = mem_rdata;
          if (idx_reg == lco_pkg::OPT2_WORD) opt2_next = mem_rdata;
          if (idx_reg == lco_pkg::LAST_WORD) begin
            state_next = ST_IDLE;
          end else begin
            idx_next   = idx_reg + 5'h01;
            state_next = ST_REQ;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      idx_reg   <= 5'h00;
      opt1_reg  <= lco_pkg::OPT_RESET;
      opt2_reg  <= lco_pkg::OPT_RESET;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      opt1_reg  <= opt1_next;
      opt2_reg  <= opt2_next;
    end
  end

  // Every constant word kept, one register each
  genvar g;
  generate
    for (g = 0; g < CONST_WORDS; g++) begin : g_words
      always_ff @(posedge clk) begin
        if (reset) begin
          word_reg[g] <= lco_pkg::OPT_RESET;
        end else if (state_reg == ST_WAIT && mem_ack && idx_reg == 5'(g)) begin
          word_reg[g] <= mem_rdata;
        end
      end
    end
  endgenerate

  // Sticky request-to-send and burst counter
  always_comb begin
    sticky_on_next = sticky_on_reg;
    if (tx_req_cmd && opts.sticky_rts) begin
      sticky_on_next = 1'b1;
    end else if (init_cmd) begin
      sticky_on_next = 1'b0;
    end
    burst_next = burst_reg;
    if (!dma_cycle) begin
      burst_next = 4'h0;
    end else if (burst_reg == lco_pkg::BURST_LIMIT) begin
      burst_next = 4'h1;
    end else begin
      burst_next = burst_reg + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sticky_on_reg <= 1'b0;
      burst_reg     <= 4'h0;
    end else begin
      sticky_on_reg <= sticky_on_next;
      burst_reg     <= burst_next;
    end
  end

  // Line pins come from another domain; only stage 2 and later are read
  always_ff @(posedge clk) begin
    if (reset) begin
      rxd_sync_reg  <= 3'h0;
      cts_sync_reg  <= 3'h0;
      tclk_sync_reg <= 3'h0;
    end else begin
      rxd_sync_reg  <= {rxd_sync_reg[1:0], serial_rx_data};
      cts_sync_reg  <= {cts_sync_reg[1:0], cts_pin};
      tclk_sync_reg <= {tclk_sync_reg[1:0], serial_tx_clock};
    end
  end

  // Pin routing and option driven outputs
  logic out_tx_n, rts_n, rxd_o_n, rxs_n, rx_start_strobe_n, bend_n, irq_n, frmr_n;
  logic [12:0] dlci_n;
  logic tclk_rise, rxd_s;
  always_comb begin
    rxd_s     = rxd_sync_reg[1];
    tclk_rise = tclk_sync_reg[1] & ~tclk_sync_reg[2];
    out_tx_n  = core_tx_data;
    rxd_o_n   = rxd_s;
    rxs_n     = 1'b1;
    if (opts.echo) begin
      out_tx_n = rxd_s;
      rxd_o_n  = 1'b1;
    end else if (opts.loopback) begin
      out_tx_n = 1'b1;
      rxd_o_n  = core_tx_data;
      rxs_n    = tclk_rise;
    end
    if (opts.loopback) begin
      rts_n = 1'b0;
    end else if (opts.tx_bypass) begin
      rts_n = core_tx_rts;
    end else if (opts.sticky_rts) begin
      rts_n = sticky_on_reg | (tx_req_cmd);
    end else begin
      rts_n = tx_pending;
    end
    rx_start_strobe_n = opts.rx_bypass & cts_sync_reg[1];
    bend_n   = opts.burst_limit && dma_cycle && burst_next == lco_pkg::BURST_LIMIT;
    irq_n    = bus_error | (event_post & ~opts.polling);
    frmr_n   = frmr_detect & opts.reject_frame_tx_enable;
    dlci_n   = {rx_dlci[12:1], rx_dlci[0] ^ opts.flip};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      out_tx_reg <= 1'b1;
      rts_reg    <= 1'b0;
      rxd_o_reg  <= 1'b1;
      rxs_reg    <= 1'b0;
      rx_start_strobe_reg <= 1'b0;
      bend_reg   <= 1'b0;
      irq_reg    <= 1'b0;
      frmr_reg   <= 1'b0;
      dlci_reg   <= 13'h0000;
    end else begin
      out_tx_reg <= out_tx_n;
      rts_reg    <= rts_n;
      rxd_o_reg  <= rxd_o_n;
      rxs_reg    <= rxs_n;
      rx_start_strobe_reg <= rx_start_strobe_n;
      bend_reg   <= bend_n;
      irq_reg    <= irq_n;
      frmr_reg   <= frmr_n;
      dlci_reg   <= dlci_n;
    end
  end

  // Registered outputs fed from next values, so they move on the state's own edge
  logic               ip_reg, ip_next;
  logic               rd_reg, rd_next;
  logic [23:0]        addr_reg, addr_next;
  logic               filt_reg, filt_next;
  logic               exp_reg, exp_next;
  logic               destuff_reg, destuff_next;
  logic               stuff_reg, stuff_next;
  lco_pkg::lco_opts_t opts_n;
  always_comb begin
    opts_n       = decode_opts(opt1_next, opt2_next);
    ip_next      = (state_next != ST_IDLE);
    rd_next      = (state_next == ST_WAIT);
    addr_next    = word_addr(idx_next);
    filt_next    = opts_n.promiscuous & opts_n.filter;
    exp_next     = ~opts_n.onchip_match;
    destuff_next = ~opts_n.rx_bypass;
    stuff_next   = ~opts_n.tx_bypass;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ip_reg      <= 1'b0;
      rd_reg      <= 1'b0;
      addr_reg    <= lco_pkg::CONST_BASE;
      filt_reg    <= 1'b0;
      exp_reg     <= 1'b1;
      destuff_reg <= 1'b1;
      stuff_reg   <= 1'b1;
    end else begin
      ip_reg      <= ip_next;
      rd_reg      <= rd_next;
      addr_reg    <= addr_next;
      filt_reg    <= filt_next;
      exp_reg     <= exp_next;
      destuff_reg <= destuff_next;
      stuff_reg   <= stuff_next;
    end
  end

  assign mem_rd                   = rd_reg;
  assign mem_addr                 = addr_reg;
  assign init_busy                = ip_reg;
  assign global_options_primary   = opt1_reg;
  assign global_options_secondary = opt2_reg;
  assign serial_tx_data           = out_tx_reg;
  assign rts_pin                  = rts_reg;
  assign core_rx_data             = rxd_o_reg;
  assign core_rx_sample           = rxs_reg;
  assign rx_start_strobe          = rx_start_strobe_reg;
  assign dma_burst_end            = bend_reg;
  assign irq                      = irq_reg;
  assign frmr_tx                  = frmr_reg;
  assign rx_dlci_eff              = dlci_reg;
  assign match_bypass             = opts.promiscuous;
  assign filter_enable            = filt_reg;
  assign expanded_mode            = exp_reg;
  assign mem_to_mem_enable        = opts.mem_to_mem_enable;
  assign protocol_variant_select  = opts.protocol_variant_select;
  assign rx_destuff_enable        = destuff_reg;
  assign tx_stuff_enable          = stuff_reg;
endmodule // lco_top

// file: verif/lco_asserts.sv
`timescale 1ns/1ps
module lco_asserts (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        init_cmd,
  input wire logic        init_busy,
  input wire logic [23:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic [15:0] global_options_primary,
  input wire logic [15:0] global_options_secondary,
  input wire logic        event_post,
  input wire logic        bus_error,
  input wire logic        irq,
  input wire logic        frmr_detect,
  input wire logic        frmr_tx,
  input wire logic [12:0] rx_dlci,
  input wire logic [12:0] rx_dlci_eff
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  word_latch_a: assert property (
    mem_rd && mem_ack && mem_addr == 24'h000000 |=> global_options_primary == $past(mem_rdata))
    else $error("option word not latched");
  read_start_a: assert property (
    init_cmd && !init_busy |-> ##2 mem_rd) else $error("load did not start");
  opts_hold_a: assert property (
    !init_busy |=> $stable(global_options_primary) && $stable(global_options_secondary))
    else $error("options moved outside load");
  irq_event_a: assert property (
    event_post && !global_options_primary[2] |=> irq) else $error("event irq missing");
  irq_poll_a: assert property (
    event_post && !bus_error && global_options_primary[2] |=> !irq)
    else $error("irq while polling");
  irq_bus_a: assert property (
    bus_error |=> irq) else $error("bus error irq missing");
  frmr_gate_a: assert property (
    frmr_detect |=> frmr_tx == $past(global_options_primary[1])) else $error("reject gate");
  flip_a: assert property (
    !$past(reset) |-> rx_dlci_eff ==
      ($past(rx_dlci) ^ {12'h000, $past(global_options_secondary[3])}))
    else $error("address flip wrong");
endmodule // lco_asserts
bind lco_top lco_asserts lco_asserts_i (
  .clk, .reset, .init_cmd, .init_busy, .mem_addr, .mem_rd, .mem_ack, .mem_rdata,
  .global_options_primary, .global_options_secondary, .event_post, .bus_error, .irq,
  .frmr_detect, .frmr_tx, .rx_dlci, .rx_dlci_eff
);

// file: verif/lco_mem_model.sv
`timescale 1ns/1ps
module lco_mem_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [23:0] mem_addr,
  input  wire logic        mem_rd,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [15:0] mem [0:23];
  logic [1:0]  wait_cnt;
  initial {mem_ack, mem_rdata, wait_cnt} = 19'h00000;
  // Lines toggle between answers so a stale word never looks valid
  always @(posedge clk) begin
    mem_ack   <= mem_rd && !mem_ack && wait_cnt == (slow ? 2'h3 : 2'h0);
    mem_rdata <= (mem_rd && !mem_ack) ? mem[mem_addr[5:1]] : ~mem_rdata;
    wait_cnt  <= (mem_rd && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
  end
endmodule // lco_mem_model

// file: verif/lco_top_tb.sv
`timescale 1ns/1ps
module lco_top_tb;
  logic        clk, reset, init_cmd, tx_req_cmd, tx_pending, mem_rd, mem_ack, init_busy, slow;
  logic        serial_tx_data, serial_rx_data, serial_tx_clock, cts_pin, rts_pin, irq;
  logic        core_tx_data, core_tx_rts, core_rx_data, core_rx_sample, rx_start_strobe;
  logic        dma_cycle, dma_burst_end, event_post, bus_error, frmr_detect, frmr_tx;
  logic        match_bypass, filter_enable, expanded_mode, mem_to_mem_enable;
  logic        protocol_variant_select, rx_destuff_enable, tx_stuff_enable;
  logic [23:0] mem_addr;
  logic [15:0] mem_rdata, global_options_primary, global_options_secondary;
  logic [12:0] rx_dlci, rx_dlci_eff;
  int          fails, check_count, n_smp;
  lco_top lco_top_i (
    .clk, .reset, .init_cmd, .tx_req_cmd, .tx_pending, .mem_addr, .mem_rd, .mem_ack,
    .mem_rdata, .init_busy, .global_options_primary, .global_options_secondary,
    .serial_tx_data, .serial_rx_data, .serial_tx_clock, .cts_pin, .rts_pin, .core_tx_data,
    .core_tx_rts, .core_rx_data, .core_rx_sample, .rx_start_strobe, .dma_cycle,
    .dma_burst_end, .event_post, .bus_error, .irq, .frmr_detect, .frmr_tx, .rx_dlci,
    .rx_dlci_eff, .match_bypass, .filter_enable, .expanded_mode, .mem_to_mem_enable,
    .protocol_variant_select, .rx_destuff_enable, .tx_stuff_enable
  );
  lco_mem_model lco_mem_model_i (.clk, .slow, .mem_addr, .mem_rd, .mem_ack, .mem_rdata);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Line clock runs free at its own phase
  initial begin
    serial_tx_clock = 1'b0;
    #7;
    forever #160 serial_tx_clock = ~serial_tx_clock;
  end
  task summarize;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Second init pulse lands mid-load and must be ignored
  task ld(input logic [15:0] w1, input logic [15:0] w2, input logic sl);
    int n;
    lco_mem_model_i.mem[0] = w1;
    lco_mem_model_i.mem[1] = w2;
    slow = sl;
    n = 0;
    for (int k = 0; k < 4; k++) @(negedge clk) init_cmd = (k % 2 == 0);
    while (init_busy !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n == 300) begin
      fails++;
      summarize();
    end
    cmp(global_options_primary, w1, "primary");
    cmp(global_options_secondary, w2, "secondary");
  endtask
  // k: 0 event, 1 bus error, 2 reject condition, 3 memory cycles
  task pulse(input int k, input int len, input logic exp);
    logic seen;
    seen = 1'b0;
    {dma_cycle, frmr_detect, bus_error, event_post} = 4'(1 << k);
    repeat (len + 3) begin
      @(negedge clk);
      if (len-- == 1) {dma_cycle, frmr_detect, bus_error, event_post} = 4'h0;
      seen |= (k == 3) ? dma_burst_end : (k == 2) ? frmr_tx : irq;
    end
    cmp({15'h0, seen}, {15'h0, exp}, "pulse");
  endtask
  initial begin
    {reset, init_cmd, tx_req_cmd, tx_pending, serial_rx_data, cts_pin} = 6'h22;
    {core_tx_data, core_tx_rts, dma_cycle, event_post, bus_error, frmr_detect, slow} = 7'h00;
    rx_dlci = 13'h0AAA;
    for (int i = 2; i < 24; i++) lco_mem_model_i.mem[i] = 16'(i * 257);
    repeat (5) @(negedge clk);
    reset = 1'b0;
    cmp({12'h000, expanded_mode, serial_tx_data, rts_pin, irq}, 16'h000C, "reset");
    ld(16'h0004, 16'h0018, 1'b0);
    pulse(0, 1, 1'b0);
    pulse(1, 1, 1'b1);
    pulse(2, 1, 1'b0);
    pulse(3, 10, 1'b0);
    cmp({3'h0, rx_dlci_eff}, 16'h0AAB, "flip");
    cmp({13'h0000, expanded_mode, protocol_variant_select, match_bypass},
        16'h0006, "mode");
    lco_mem_model_i.mem[0] = 16'h2000;
    repeat (4) @(negedge clk);
    cmp(global_options_primary, 16'h0004, "stale");
    ld(16'h1213, 16'h0000, 1'b1);
    pulse(0, 1, 1'b1);
    pulse(2, 1, 1'b1);
    pulse(3, 10, 1'b1);
    cmp({13'h0000, match_bypass, filter_enable, expanded_mode},
        16'h0004, "match");
    cmp({15'h0, rts_pin}, 16'h0000, "rts");
    tx_req_cmd = 1'b1;
    @(negedge clk) tx_req_cmd = 1'b0;
    repeat (4) @(negedge clk);
    cmp({15'h0, rts_pin}, 16'h0001, "sticky");
    ld(16'h2000, 16'h0000, 1'b0);
    cmp({15'h0, rts_pin}, 16'h0000, "rts");
    {tx_pending, serial_rx_data} = 2'h2;
    repeat (4) @(negedge clk);
    cmp({13'h0000, serial_tx_data, rts_pin, core_rx_data}, 16'h0003, "echo");
    {tx_pending, serial_rx_data} = 2'h1;
    repeat (4) @(negedge clk);
    cmp({13'h0000, serial_tx_data, rts_pin, core_rx_data}, 16'h0005, "echo");
    ld(16'h0938, 16'h0000, 1'b0);
    {cts_pin, core_tx_rts, serial_rx_data} = 3'h6;
    repeat (4) @(negedge clk);
    cmp({8'h00, filter_enable, mem_to_mem_enable, rx_destuff_enable, tx_stuff_enable,
         rx_start_strobe, rts_pin, core_rx_data, core_rx_sample},
        16'h00CD, "bypass");
    {cts_pin, core_tx_rts, serial_rx_data} = 3'h1;
    ld(16'h0400, 16'h0000, 1'b0);
    tx_pending = 1'b1;
    repeat (4) @(negedge clk);
    cmp({13'h0000, serial_tx_data, rts_pin, core_rx_data}, 16'h0004, "loop");
    // Line clock is 8 system clocks long: two sample pulses per 16 cycles
    n_smp = 0;
    repeat (16) @(negedge clk) n_smp += core_rx_sample;
    cmp(16'(n_smp), 16'h0002, "loop clock");
    summarize();
  end
endmodule // lco_top_tb
